// ===== logic/rst_boot_pkg.sv
package rst_boot_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [3:0] PUD_OFFSET    = 4'h0;   // pull-up disable register
   localparam logic [3:0] STATUS_OFFSET = 4'h4;   // latched boot state, read only
   localparam logic [3:0] CTRL_OFFSET   = 4'h8;   // not decoded, writes and reads get a slave error

   // pull-up disable field positions
   localparam int PUD_RESET_BIT = 0;
   localparam int PUD_BOOT_BIT  = 1;
   localparam int PUD_WIDTH_BIT = 2;
   localparam logic [2:0] PUD_RESET_VAL = 3'h0;

   // status field positions
   localparam int ST_BOOT_SOURCE_STRAP_BIT = 0;
   localparam int ST_WIDE_BIT    = 1;
   localparam int ST_SECURE_BIT  = 2;
   localparam int ST_INRST_BIT   = 3;

   // address line counts
   localparam logic [4:0] ADDR_LINES_NARROW = 5'h10;  // 16 lines
   localparam logic [4:0] ADDR_LINES_WIDE   = 5'h14;  // 20 lines

   // timing: release delay after the pin rises and power-on hold, in internal clocks
   localparam int RELEASE_CYCLES = 32;
   localparam int POR_CYCLES     = 16;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // sequencer states, gray coded along power-on, held, counting, run
   typedef enum logic [1:0] {
      ST_POR   = 2'b00,
      ST_HELD  = 2'b01,
      ST_COUNT = 2'b11,
      ST_RUN   = 2'b10
   } seq_t;

endpackage : rst_boot_pkg

// ===== logic/reset_and_boot_mode_latch.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// How it works
// - while the reset pin is low, internal reset and pull-up disables initialize and stay held.
// - on pin release, the boot mode is captured from the boot source strap.
// - internal reset drops on the clock, fixed cycles after pin release.
// - reset out pin follows the internal reset state at all times.
// - power-on reset holds the chip in reset, independent of the pin.
// - pin reset alone spares debug; full reset needs pin and test reset.
// - strap high boots off-chip unless flash is secured; low boots internally.
// - width strap high adds four address lines, twenty total, gated by boot mode.
// - the reset-pin pull-up disable bit switches off that pull-up.
// - the boot strap pull-up disable bit switches off that pull-up.
// - the width strap pull-up disable bit switches off that pull-up.
// - secured flash with external request falls back to internal boot.
// - internal boot uses sixteen lines; only external boot honours width strap.

module reset_and_boot_mode_latch #(
   parameter int RELEASE_CNT = rst_boot_pkg::RELEASE_CYCLES,
   parameter int POR_CNT     = rst_boot_pkg::POR_CYCLES
) (
   // clock and power-on reset
   input  wire  logic        CLK_I,
   input  wire  logic        RST_I,
   // board pins
   input  wire  logic        RESET_PIN_N_I,
   input  wire  logic        TEST_RESET_N_I,
   input  wire  logic        BOOT_SOURCE_STRAP_I,
   input  wire  logic        MEM_WIDTH_STRAP_I,
   input  wire  logic        FLASH_SECURED_I,
   output logic              RESET_OUT_PIN_N_O,
   output logic              CHIP_RESET_O,
   output logic              DEBUG_RESET_O,
   output logic              RESET_PULLUP_EN_O,
   output logic              BOOT_PULLUP_EN_O,
   output logic              WIDTH_PULLUP_EN_O,
   // latched boot configuration
   output logic              EXT_BOOT_O,
   output logic              SECURE_O,
   output logic [4:0]        ADDR_LINES_O,
   // axi4-lite slave
   input  wire  logic [3:0]  S_AXI_AWADDR,
   input  wire  logic        S_AXI_AWVALID,
   output logic              S_AXI_AWREADY,
   input  wire  logic [31:0] S_AXI_WDATA,
   input  wire  logic [3:0]  S_AXI_WSTRB,
   input  wire  logic        S_AXI_WVALID,
   output logic              S_AXI_WREADY,
   output logic [1:0]        S_AXI_BRESP,
   output logic              S_AXI_BVALID,
   input  wire  logic        S_AXI_BREADY,
   input  wire  logic [3:0]  S_AXI_ARADDR,
   input  wire  logic        S_AXI_ARVALID,
   output logic              S_AXI_ARREADY,
   output logic [31:0]       S_AXI_RDATA,
   output logic [1:0]        S_AXI_RRESP,
   output logic              S_AXI_RVALID,
   input  wire  logic        S_AXI_RREADY
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      rst_boot_pkg::seq_t seq;
      logic [15:0]        cnt;
      logic               in_rst;
      logic               dbg_rst;
      logic               ext_boot;
      logic               secure;
      logic               wide;
      logic [2:0]         pud;
      logic               aw_got;
      logic               w_got;
      logic [3:0]         aw_addr;
      logic [31:0]        w_data;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   // one process holds sequencer and bus slave so the struct has one driver
   always_comb begin
      st_nxt = st_r;
      // debug reset only with test reset
      st_nxt.dbg_rst = ~TEST_RESET_N_I;
      case (st_r.seq)
         rst_boot_pkg::ST_POR: begin
            st_nxt.in_rst = 1'b1;
            st_nxt.cnt    = st_r.cnt + 16'h0001;
            if (st_r.cnt >= 16'(POR_CNT - 1)) begin
               st_nxt.seq = rst_boot_pkg::ST_HELD;
               st_nxt.cnt = 16'h0000;
            end
         end
         rst_boot_pkg::ST_HELD: begin
            st_nxt.in_rst = 1'b1;
            st_nxt.pud    = rst_boot_pkg::PUD_RESET_VAL;
            if (RESET_PIN_N_I) begin
               st_nxt.ext_boot = BOOT_SOURCE_STRAP_I & ~FLASH_SECURED_I;
               st_nxt.secure   = FLASH_SECURED_I;
               // width strap only counts in external boot
               st_nxt.wide     = MEM_WIDTH_STRAP_I & BOOT_SOURCE_STRAP_I
                                 & ~FLASH_SECURED_I;
               st_nxt.seq      = rst_boot_pkg::ST_COUNT;
               st_nxt.cnt      = 16'h0000;
            end
         end
         rst_boot_pkg::ST_COUNT: begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
            if (!RESET_PIN_N_I) begin
               st_nxt.seq = rst_boot_pkg::ST_HELD;
            end else if (st_r.cnt >= 16'(RELEASE_CNT - 1)) begin
               st_nxt.seq    = rst_boot_pkg::ST_RUN;
               st_nxt.in_rst = 1'b0;
            end
         end
         default: begin
            if (!RESET_PIN_N_I) begin
               st_nxt.seq    = rst_boot_pkg::ST_HELD;
               st_nxt.in_rst = 1'b1;
            end
         end
      endcase

      // write channel: address and data taken in either order
      if (S_AXI_AWVALID && !st_r.aw_got && !st_r.bvalid) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !st_r.w_got && !st_r.bvalid) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = S_AXI_WDATA;
      end
      if (st_r.aw_got && st_r.w_got) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = rst_boot_pkg::RESP_OKAY;
         if (st_r.aw_addr == rst_boot_pkg::PUD_OFFSET) begin
            // pull-up disables written only out of reset
            if (!st_r.in_rst && S_AXI_WSTRB[0]) begin
               st_nxt.pud = st_r.w_data[2:0];
            end
         end else if (st_r.aw_addr == rst_boot_pkg::STATUS_OFFSET) begin
            st_nxt.bresp = rst_boot_pkg::RESP_OKAY;
         end else begin
            st_nxt.bresp = rst_boot_pkg::RESP_SLVERR;
         end
      end
      if (st_r.bvalid && S_AXI_BREADY) begin
         st_nxt.bvalid = 1'b0;
      end

      // read channel
      st_nxt.arready = 1'b0;
      if (S_AXI_ARVALID && !st_r.arready && !st_r.rvalid) begin
         st_nxt.arready = 1'b1;
         st_nxt.rvalid  = 1'b1;
         st_nxt.rresp   = rst_boot_pkg::RESP_OKAY;
         st_nxt.rdata   = 32'h0000_0000;
         if (S_AXI_ARADDR == rst_boot_pkg::PUD_OFFSET) begin
            st_nxt.rdata[2:0] = st_r.pud;
         end else if (S_AXI_ARADDR == rst_boot_pkg::STATUS_OFFSET) begin
            st_nxt.rdata[rst_boot_pkg::ST_BOOT_SOURCE_STRAP_BIT] = st_r.ext_boot;
            st_nxt.rdata[rst_boot_pkg::ST_WIDE_BIT]    = st_r.wide;
            st_nxt.rdata[rst_boot_pkg::ST_SECURE_BIT]  = st_r.secure;
            st_nxt.rdata[rst_boot_pkg::ST_INRST_BIT]   = st_r.in_rst;
         end else begin
            st_nxt.rresp = rst_boot_pkg::RESP_SLVERR;
         end
      end
      if (st_r.rvalid && S_AXI_RREADY) begin
         st_nxt.rvalid = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // power-on reset restarts the whole sequence
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         st_r         <= '0;
         st_r.seq     <= rst_boot_pkg::ST_POR;
         st_r.in_rst  <= 1'b1;
         st_r.dbg_rst <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all from flops through at most an inverter, a gate or a mux
   // ------------------------------------------------------------------
   // reset out follows internal reset
   assign RESET_OUT_PIN_N_O = ~st_r.in_rst;
   assign CHIP_RESET_O      = st_r.in_rst;
   assign DEBUG_RESET_O     = st_r.dbg_rst;
   assign RESET_PULLUP_EN_O = ~st_r.pud[rst_boot_pkg::PUD_RESET_BIT];
   assign BOOT_PULLUP_EN_O  = ~st_r.pud[rst_boot_pkg::PUD_BOOT_BIT];
   assign WIDTH_PULLUP_EN_O = ~st_r.pud[rst_boot_pkg::PUD_WIDTH_BIT];
   assign EXT_BOOT_O        = st_r.ext_boot;
   assign SECURE_O          = st_r.secure;
   assign ADDR_LINES_O      = st_r.wide ? rst_boot_pkg::ADDR_LINES_WIDE
                                        : rst_boot_pkg::ADDR_LINES_NARROW;
   assign S_AXI_AWREADY     = ~st_r.aw_got & ~st_r.bvalid;
   assign S_AXI_WREADY      = ~st_r.w_got & ~st_r.bvalid;
   assign S_AXI_BVALID      = st_r.bvalid;
   assign S_AXI_BRESP       = st_r.bresp;
   assign S_AXI_ARREADY     = st_r.arready;
   assign S_AXI_RVALID      = st_r.rvalid;
   assign S_AXI_RDATA       = st_r.rdata;
   assign S_AXI_RRESP       = st_r.rresp;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   sequence pin_rise_s;
      !$past(RESET_PIN_N_I) && RESET_PIN_N_I && st_r.seq == rst_boot_pkg::ST_HELD;
   endsequence

   a_pin_holds_reset: assert property (@(posedge CLK_I) disable iff (RST_I)
      !RESET_PIN_N_I |=> st_r.in_rst)
      else $error("internal reset released while pin low");

   a_boot_capture: assert property (@(posedge CLK_I) disable iff (RST_I)
      (st_r.seq == rst_boot_pkg::ST_HELD && RESET_PIN_N_I) |=>
      st_r.ext_boot == ($past(BOOT_SOURCE_STRAP_I) & ~$past(FLASH_SECURED_I)))
      else $error("boot mode not captured at release");

   a_release_delay: assert property (@(posedge CLK_I) disable iff (RST_I)
      (st_r.seq == rst_boot_pkg::ST_COUNT && st_r.cnt == 16'h0000 && RESET_PIN_N_I)
      ##1 RESET_PIN_N_I [*1] |-> st_r.in_rst)
      else $error("internal reset released too early");

   a_out_follows: assert property (@(posedge CLK_I) disable iff (RST_I)
      RESET_OUT_PIN_N_O == ~CHIP_RESET_O)
      else $error("reset out pin does not follow internal reset");

   // the shortest legal power-on stretch is two cycles, so only those are checked here
   a_por_hold: assert property (@(posedge CLK_I)
      $fell(RST_I) |-> CHIP_RESET_O [*2])
      else $error("power-on reset not held");

   a_debug_spared: assert property (@(posedge CLK_I) disable iff (RST_I)
      TEST_RESET_N_I |=> !DEBUG_RESET_O)
      else $error("debug reset without test reset");

   a_secure_internal: assert property (@(posedge CLK_I) disable iff (RST_I)
      SECURE_O |-> !EXT_BOOT_O && ADDR_LINES_O == rst_boot_pkg::ADDR_LINES_NARROW)
      else $error("secured flash allowed external boot");

   a_mode_stable: assert property (@(posedge CLK_I) disable iff (RST_I)
      (st_r.seq == rst_boot_pkg::ST_RUN && RESET_PIN_N_I) |=> $stable(EXT_BOOT_O))
      else $error("boot mode changed outside reset");

   a_pud_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
      st_r.seq == rst_boot_pkg::ST_HELD |=> RESET_PULLUP_EN_O && BOOT_PULLUP_EN_O)
      else $error("pull-up disabled during reset");

   a_width_pud_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
      st_r.seq == rst_boot_pkg::ST_HELD |=> WIDTH_PULLUP_EN_O)
      else $error("width strap pull-up disabled during reset");

   a_capture_step: assert property (@(posedge CLK_I) disable iff (RST_I)
      pin_rise_s |=> st_r.seq == rst_boot_pkg::ST_COUNT)
      else $error("pin release did not start the release count");

   a_run_released: assert property (@(posedge CLK_I) disable iff (RST_I)
      st_r.seq == rst_boot_pkg::ST_RUN |-> !CHIP_RESET_O)
      else $error("internal reset active in run state");

   a_out_low_rst: assert property (@(posedge CLK_I) disable iff (RST_I)
      CHIP_RESET_O |-> !RESET_OUT_PIN_N_O)
      else $error("reset out pin high during internal reset");

   a_ext_unsecured: assert property (@(posedge CLK_I) disable iff (RST_I)
      EXT_BOOT_O |-> !SECURE_O)
      else $error("external boot with secured flash");

   a_wide_needs_ext: assert property (@(posedge CLK_I) disable iff (RST_I)
      ADDR_LINES_O == rst_boot_pkg::ADDR_LINES_WIDE |-> EXT_BOOT_O)
      else $error("twenty address lines without external boot");

   a_width_stable: assert property (@(posedge CLK_I) disable iff (RST_I)
      (st_r.seq == rst_boot_pkg::ST_RUN && RESET_PIN_N_I) |=>
      $stable(ADDR_LINES_O) && $stable(SECURE_O))
      else $error("address width or security changed outside reset");

   // bus: write response held until taken
   a_bvalid_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped before ready");

   // bus: read data held until taken
   a_rvalid_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped before ready");

   // bus: address ready is a single pulse
   a_arready_pulse: assert property (@(posedge CLK_I) disable iff (RST_I)
      S_AXI_ARREADY |=> !S_AXI_ARREADY)
      else $error("read address ready held longer than one cycle");

endmodule : reset_and_boot_mode_latch

// ===== verification/board_strap_model.sv
`timescale 1ns/1ps
module board_strap_model (
   // straps, [0] boot source, [1] memory width
   input  wire logic       clk_i,
   input  wire logic [1:0] tie_i,
   input  wire logic [1:0] open_i,
   input  wire logic [1:0] pull_i,
   output logic      [1:0] strap_o
);
   logic [1:0] flip_r = 2'h0;
   // an open pin with no pull-up wanders, so it must never read as a steady level
   always_ff @(posedge clk_i) flip_r <= ~flip_r;
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         strap_o[k] = open_i[k] ? (pull_i[k] ? 1'b1 : flip_r[k]) : tie_i[k];
      end
   end
endmodule : board_strap_model

// ===== verification/reset_and_boot_mode_latch_tb_top.sv
`timescale 1ns/1ps
module reset_and_boot_mode_latch_tb_top;
   logic        clk = 1'b0, rst = 1'b1, pin_n = 1'b1, trst_n = 1'b1, sec = 1'b0;
   logic [1:0]  tie = 2'h0, opn = 2'h0, strap, bresp, rresp;
   logic        rout_n, chip_rst, dbg_rst, rpu, bpu, wpu, ext, secure;
   logic [4:0]  lines;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [33:0] e;
   logic [33:0] rq[$];
   logic [1:0]  wq[$];
   int          mismatches = 0, total_checks = 0, cyc = 0;
   // release count shortened so each boot pass stays quick
   localparam int REL_CNT = 2;

   reset_and_boot_mode_latch #(.RELEASE_CNT(REL_CNT), .POR_CNT(2)) dut (
      .CLK_I(clk), .RST_I(rst), .RESET_PIN_N_I(pin_n), .TEST_RESET_N_I(trst_n),
      .BOOT_SOURCE_STRAP_I(strap[0]), .MEM_WIDTH_STRAP_I(strap[1]), .FLASH_SECURED_I(sec),
      .RESET_OUT_PIN_N_O(rout_n), .CHIP_RESET_O(chip_rst), .DEBUG_RESET_O(dbg_rst),
      .RESET_PULLUP_EN_O(rpu), .BOOT_PULLUP_EN_O(bpu), .WIDTH_PULLUP_EN_O(wpu),
      .EXT_BOOT_O(ext), .SECURE_O(secure), .ADDR_LINES_O(lines),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   board_strap_model board (.clk_i(clk), .tie_i(tie), .open_i(opn), .pull_i({wpu, bpu}),
                            .strap_o(strap));

   // 200 MHz clock
   initial forever #2.5 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up

   // one bus transfer; the expected answer is noted before the request goes out
   task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] dv,
                      input logic [1:0] er);
      int n;
      n = 0;
      if (wr) wq.push_back(er);
      else rq.push_back({er, dv});
      awaddr  <= a;
      araddr  <= a;
      wdata   <= dv;
      awvalid <= wr;
      wvalid  <= wr;
      bready  <= wr;
      arvalid <= !wr;
      rready  <= !wr;
      while (n < 60) begin
         @(posedge clk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (arready === 1'b1) arvalid <= 1'b0;
         if ((wr ? bvalid : rvalid) === 1'b1) begin
            bready <= 1'b0;
            rready <= 1'b0;
            n = 99;
         end
      end
      if (n == 60) begin
         mismatches++;
         wrap_up();
      end
      @(posedge clk);
   endtask : axi

   // answers are matched to the oldest note
   always @(posedge clk) begin
      if (bvalid === 1'b1 && bready) chk(32'(bresp), 32'(wq.pop_front()));
      if (rvalid === 1'b1 && rready) begin
         e = rq.pop_front();
         chk(32'(rresp), 32'(e[33:32]));
         if (e[33:32] == rst_boot_pkg::RESP_OKAY) chk(rdata, e[31:0]);
      end
   end

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         mismatches++;
         wrap_up();
      end
   end

   // one pin reset with given straps, then the latched outcome
   task automatic boot(input logic b, input logic w, input logic s, input logic op);
      logic ex, wd;
      int   n;
      ex = b & !s;
      wd = ex & w;
      n = 0;
      pin_n <= 1'b0;
      tie   <= {w, b};
      opn   <= {op, op};
      sec   <= s;
      repeat (4) @(posedge clk);
      chk(32'({rout_n, chip_rst, dbg_rst, rpu, bpu, wpu}), 32'h17);
      axi(1'b1, rst_boot_pkg::PUD_OFFSET, 32'h7, rst_boot_pkg::RESP_OKAY);
      axi(1'b0, rst_boot_pkg::PUD_OFFSET, 32'h0, rst_boot_pkg::RESP_OKAY);
      pin_n <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (chip_rst !== 1'b0 && n < 100);
      // one edge to see the pin, the count, one edge to see the flop
      chk(n, 32'(REL_CNT + 2));
      tie <= ~{w, b};
      opn <= 2'h0;
      repeat (2) @(posedge clk);
      chk(32'({rout_n, ext, secure, lines == rst_boot_pkg::ADDR_LINES_WIDE}),
          32'({1'b1, ex, s, wd}));
      chk(32'(lines), wd ? 32'(rst_boot_pkg::ADDR_LINES_WIDE)
                         : 32'(rst_boot_pkg::ADDR_LINES_NARROW));
      axi(1'b0, rst_boot_pkg::STATUS_OFFSET, {28'h0, 1'b0, s, wd, ex},
          rst_boot_pkg::RESP_OKAY);
   endtask : boot

   // main sequence
   initial begin
      void'($urandom(44));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(32'({chip_rst, rout_n, rpu, bpu, wpu}), 32'h17);
      for (int i = 0; i < 8; i++) begin
         boot(i[0], i[1], i[2], 1'b0);
      end
      boot(1'b1, 1'b1, 1'b0, 1'b1);
      repeat (3) begin
         d = $urandom;
         axi(1'b1, rst_boot_pkg::PUD_OFFSET, d, rst_boot_pkg::RESP_OKAY);
         axi(1'b0, rst_boot_pkg::PUD_OFFSET, 32'(d[2:0]), rst_boot_pkg::RESP_OKAY);
         chk(32'({rpu, bpu, wpu}), 32'({~d[0], ~d[1], ~d[2]}));
      end
      axi(1'b1, rst_boot_pkg::CTRL_OFFSET, d, rst_boot_pkg::RESP_SLVERR);
      axi(1'b0, rst_boot_pkg::CTRL_OFFSET, 32'h0, rst_boot_pkg::RESP_SLVERR);
      axi(1'b1, rst_boot_pkg::STATUS_OFFSET, 32'hf, rst_boot_pkg::RESP_OKAY);
      axi(1'b0, rst_boot_pkg::STATUS_OFFSET, 32'h3, rst_boot_pkg::RESP_OKAY);
      trst_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'({dbg_rst, chip_rst}), 32'h2);
      trst_n <= 1'b1;
      pin_n  <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'({rpu, bpu, wpu}), 32'h7);
      // power-on reset again while the pin is released
      rst   <= 1'b1;
      pin_n <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(32'({chip_rst, rout_n, rpu, bpu, wpu}), 32'h17);
      repeat (10) @(posedge clk);
      chk(32'({chip_rst, rout_n}), 32'h1);
      wrap_up();
   end
endmodule : reset_and_boot_mode_latch_tb_top
